/* logic/cam_consts.svh */
// register map, field positions, reset values and divider codes of the clock accuracy monitor
// assumes a 12-bit apb byte address with 32-bit data
`ifndef CAM_CONSTS_SVH
`define CAM_CONSTS_SVH
`define CAM_ADDR_W 12
`define CAM_OFF_CFG 12'h000
`define CAM_OFF_CMD 12'h004
`define CAM_OFF_STAT 12'h008
`define CAM_OFF_MASK 12'h00C
`define CAM_OFF_UPPER 12'h010
`define CAM_OFF_LOWER 12'h014
`define CAM_OFF_COUNT 12'h018
`define CAM_OFF_RESULT 12'h01C
`define CAM_CFG_REF 8:0
`define CAM_CFG_CONT 9
`define CAM_CMD_START 0
`define CAM_CMD_STOP 1
`define CAM_CMD_CLEAR 2
`define CAM_FLAGS 2:0
`define CAM_FLAG_MEND 0
`define CAM_FLAG_FERR 1
`define CAM_FLAG_OVF 2
`define CAM_STAT_BUSY 8
`define CAM_CFG_RST 10'h200
`define CAM_MASK_RST 3'h7
`define CAM_FLAGS_NONE 3'h0
`define CAM_FLAGS_ALL 3'h7
`define CAM_LIMIT_RST '0
`define CAM_MDIV_MASK_1 5'h00
`define CAM_MDIV_MASK_4 5'h03
`define CAM_MDIV_MASK_8 5'h07
`define CAM_MDIV_MASK_32 5'h1F
`define CAM_RDIV_BIT_32 4'h4
`define CAM_RDIV_BIT_128 4'h6
`define CAM_RDIV_BIT_1024 4'h9
`define CAM_RDIV_BIT_8192 4'hC
`define CAM_FILT_MASK_1 4'h0
`define CAM_FILT_MASK_4 4'h3
`define CAM_FILT_MASK_16 4'hF
`endif

/* logic/cam_pkg.sv */
// types shared by the clock accuracy monitor and its reference conditioner
// assumes nothing beyond a systemverilog compiler
package cam_pkg;
    typedef enum logic [1:0] {
        edge_rise = 2'b00,
        edge_fall = 2'b01,
        edge_both = 2'b10
    } edge_sel_t;
    typedef enum logic [1:0] {
        filt_off = 2'b00,
        filt_div1 = 2'b01,
        filt_div4 = 2'b10,
        filt_div16 = 2'b11
    } filt_sel_t;
    typedef struct packed {
        logic [1:0] mdiv;
        logic [1:0] rdiv;
        logic ext;
        filt_sel_t filt;
        edge_sel_t edge_sel;
    } ref_cfg_t;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_arm = 2'b01,
        st_count = 2'b10
    } meas_state_t;
endpackage

/* logic/cam_ref_if.sv */
// carrier between the monitor core and its reference conditioner
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface cam_ref_if;
    import cam_pkg::*;
    logic ce;
    logic meas_clk_in;
    logic int_ref_clk_in;
    logic ext_ref_clock_in;
    ref_cfg_t cfg;
    logic tick;
    logic ref_edge;
    modport cond (
        input ce, meas_clk_in, int_ref_clk_in, ext_ref_clock_in, cfg,
        output tick, ref_edge
    );
    modport core (
        output ce, meas_clk_in, int_ref_clk_in, ext_ref_clock_in, cfg,
        input tick, ref_edge
    );
endinterface
`default_nettype wire

/* logic/cam_ref_cond.sv */
// reference conditioner: measurement divider, reference divider, filter, edge detection
// assumes clock pins are sampled levels far slower than pclk
`timescale 1ns/1ps
`default_nettype none
`include "cam_consts.svh"
module cam_ref_cond
    import cam_pkg::*;
#(
    parameter int FILT_LEN = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins, configuration and strobes
    cam_ref_if.cond rif
);
    if (FILT_LEN < 2 || FILT_LEN > 8) begin : g_bad_filt
        $error("cam_ref_cond: FILT_LEN must be 2 to 8");
    end

    typedef struct packed {
        logic meas_s1;
        logic meas_s2;
        logic meas_d;
        logic [4:0] mcnt;
        logic iref_s1;
        logic iref_s2;
        logic iref_d;
        logic [12:0] rcnt;
        logic eref_s1;
        logic eref_s2;
        logic [3:0] fcnt;
        logic [FILT_LEN-1:0] fhist;
        logic fout;
        logic ref_prev;
        logic tick;
        logic ref_edge;
    } cond_state_t;

    cond_state_t s;
    cond_state_t next_s;
    logic medge;
    logic mtick;
    logic samp;
    logic ref_sel;
    logic [4:0] mmask;
    logic [3:0] fmask;

    function automatic logic [4:0] meas_mask(input logic [1:0] sel);
        case (sel)
            2'h0: meas_mask = `CAM_MDIV_MASK_1;
            2'h1: meas_mask = `CAM_MDIV_MASK_4;
            2'h2: meas_mask = `CAM_MDIV_MASK_8;
            default: meas_mask = `CAM_MDIV_MASK_32;
        endcase
    endfunction

    function automatic logic [3:0] ref_bit(input logic [1:0] sel);
        case (sel)
            2'h0: ref_bit = `CAM_RDIV_BIT_32;
            2'h1: ref_bit = `CAM_RDIV_BIT_128;
            2'h2: ref_bit = `CAM_RDIV_BIT_1024;
            default: ref_bit = `CAM_RDIV_BIT_8192;
        endcase
    endfunction

    always_comb begin
        next_s = s;
        mmask = meas_mask(rif.cfg.mdiv);
        fmask = (rif.cfg.filt == filt_div16) ? `CAM_FILT_MASK_16 :
                (rif.cfg.filt == filt_div4) ? `CAM_FILT_MASK_4 : `CAM_FILT_MASK_1;
        next_s.meas_s1 = rif.meas_clk_in;
        next_s.meas_s2 = s.meas_s1;
        next_s.meas_d = s.meas_s2;
        medge = s.meas_s2 && !s.meas_d;
        mtick = medge && ((s.mcnt & mmask) == mmask);
        if (medge) begin
            next_s.mcnt = s.mcnt + 5'h01;
        end
        next_s.iref_s1 = rif.int_ref_clk_in;
        next_s.iref_s2 = s.iref_s1;
        next_s.iref_d = s.iref_s2;
        if (s.iref_s2 && !s.iref_d) begin
            next_s.rcnt = s.rcnt + 13'h0001;
        end
        next_s.eref_s1 = rif.ext_ref_clock_in;
        next_s.eref_s2 = s.eref_s1;
        samp = mtick && ((s.fcnt & fmask) == fmask);
        if (mtick) begin
            next_s.fcnt = s.fcnt + 4'h1;
        end
        // a level must hold for FILT_LEN samples before the filter output follows it
        if (samp) begin
            next_s.fhist = {s.fhist[FILT_LEN-2:0], s.eref_s2};
            if (&next_s.fhist) begin
                next_s.fout = 1'b1;
            end else if (~|next_s.fhist) begin
                next_s.fout = 1'b0;
            end
        end
        if (!rif.cfg.ext) begin
            ref_sel = s.rcnt[ref_bit(rif.cfg.rdiv)];
        end else if (rif.cfg.filt == filt_off) begin
            ref_sel = s.eref_s2;
        end else begin
            ref_sel = s.fout;
        end
        next_s.tick = mtick;
        next_s.ref_edge = 1'b0;
        if (mtick) begin
            next_s.ref_prev = ref_sel;
            case (rif.cfg.edge_sel)
                edge_rise: next_s.ref_edge = ref_sel && !s.ref_prev;
                edge_fall: next_s.ref_edge = !ref_sel && s.ref_prev;
                default: next_s.ref_edge = ref_sel != s.ref_prev;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (rif.ce) begin
            s <= next_s;
        end
    end

    assign rif.tick = s.tick;
    assign rif.ref_edge = s.ref_edge;
endmodule // cam_ref_cond
`default_nettype wire

/* logic/clock_accuracy_monitor.sv */
// clock accuracy monitor: apb registers, measurement sequencer, limit check, interrupt
// assumes clock pins sampled by pclk and an apb3 master without wait-state limits
//
// What this block does
// - count between two successive valid reference edges
// - valid edge is rising, falling or both
// - count divided measurement clock by 1/4/8/32
// - divide internal reference by 32/128/1024/8192
// - external reference undivided, filtered only when enabled
// - good when lower <= count <= upper
// - out of range count flags frequency error
// - continuous mode restarts after every completion
// - single mode stops and keeps result
// - frequency error interrupt when enabled
// - overflow flag and interrupt past the all-ones count (0xFFFF at CNT_W 16)
// - measurement end interrupt when in range
// - status and live counter always readable
// - filter off, or sample at rate /1, /4, /16
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cam_consts.svh"
module clock_accuracy_monitor
    import cam_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int FILT_LEN = 3
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic [`CAM_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clocks under test
    input wire logic meas_clk_in,
    input wire logic int_ref_clk_in,
    input wire logic ext_ref_clock_in,
    // interrupt
    output logic irq
);
    if (CNT_W < 8 || CNT_W > 32) begin : g_bad_cnt
        $error("clock_accuracy_monitor: CNT_W must be 8 to 32");
    end

    localparam logic [CNT_W-1:0] CNT_ONE = 1;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    typedef struct packed {
        ref_cfg_t rcfg;
        logic cont;
        logic [2:0] mask;
        logic [CNT_W-1:0] upper;
        logic [CNT_W-1:0] lower;
        logic [2:0] flags;
        meas_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] result;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } mon_state_t;

    mon_state_t s;
    mon_state_t next_s;

    cam_ref_if rif ();

    logic setup;
    logic access;
    logic wr_ok;
    logic busy;
    logic start_cmd;
    logic stop_cmd;
    logic clear_cmd;
    logic [2:0] events;
    logic [2:0] clr_mask;
    logic [CNT_W-1:0] fin;

    function automatic logic in_limits(
        input logic [CNT_W-1:0] v,
        input logic [CNT_W-1:0] lo,
        input logic [CNT_W-1:0] hi
    );
        in_limits = (v <= hi) && (v >= lo);
    endfunction

    function automatic logic is_cfg_reg(input logic [`CAM_ADDR_W-1:0] a);
        is_cfg_reg = (a == `CAM_OFF_CFG) || (a == `CAM_OFF_UPPER) || (a == `CAM_OFF_LOWER);
    endfunction

    assign rif.ce = ce;
    assign rif.meas_clk_in = meas_clk_in;
    assign rif.int_ref_clk_in = int_ref_clk_in;
    assign rif.ext_ref_clock_in = ext_ref_clock_in;
    assign rif.cfg = s.rcfg;

    cam_ref_cond #(
        .FILT_LEN(FILT_LEN)
    ) u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif.cond)
    );

    always_comb begin
        next_s = s;
        events = `CAM_FLAGS_NONE;
        clr_mask = `CAM_FLAGS_NONE;
        fin = s.cnt;
        busy = s.st != st_idle;
        setup = psel && !penable;
        access = psel && penable;
        // a write refused at setup is already flagged in pslverr and must not land
        wr_ok = access && pwrite && !s.pslverr;
        start_cmd = wr_ok && (paddr == `CAM_OFF_CMD) && pwdata[`CAM_CMD_START];
        stop_cmd = wr_ok && (paddr == `CAM_OFF_CMD) && pwdata[`CAM_CMD_STOP];
        clear_cmd = wr_ok && (paddr == `CAM_OFF_CMD) && pwdata[`CAM_CMD_CLEAR];

        // read data and error are prepared in the setup cycle so both come from flops
        if (setup) begin
            next_s.prdata = '0;
            next_s.pslverr = 1'b0;
            if (paddr == `CAM_OFF_CFG) begin
                next_s.prdata[`CAM_CFG_REF] = s.rcfg;
                next_s.prdata[`CAM_CFG_CONT] = s.cont;
            end else if (paddr == `CAM_OFF_CMD) begin
                next_s.prdata = '0;
            end else if (paddr == `CAM_OFF_STAT) begin
                next_s.prdata[`CAM_FLAGS] = s.flags;
                next_s.prdata[`CAM_STAT_BUSY] = busy;
            end else if (paddr == `CAM_OFF_MASK) begin
                next_s.prdata[`CAM_FLAGS] = s.mask;
            end else if (paddr == `CAM_OFF_UPPER) begin
                next_s.prdata = 32'(s.upper);
            end else if (paddr == `CAM_OFF_LOWER) begin
                next_s.prdata = 32'(s.lower);
            end else if (paddr == `CAM_OFF_COUNT) begin
                next_s.prdata = 32'(s.cnt);
            end else if (paddr == `CAM_OFF_RESULT) begin
                next_s.prdata = 32'(s.result);
            end else begin
                next_s.pslverr = 1'b1;
            end
            // changing limits or dividers mid-measurement would corrupt the count
            if (pwrite && busy && is_cfg_reg(paddr)) begin
                next_s.pslverr = 1'b1;
            end
        end

        if (wr_ok) begin
            if (paddr == `CAM_OFF_CFG) begin
                next_s.rcfg = pwdata[`CAM_CFG_REF];
                next_s.cont = pwdata[`CAM_CFG_CONT];
            end else if (paddr == `CAM_OFF_MASK) begin
                next_s.mask = pwdata[`CAM_FLAGS];
            end else if (paddr == `CAM_OFF_UPPER) begin
                next_s.upper = pwdata[CNT_W-1:0];
            end else if (paddr == `CAM_OFF_LOWER) begin
                next_s.lower = pwdata[CNT_W-1:0];
            end
        end

        // a status read clears only the flags it actually returned
        if (access && !pwrite && (paddr == `CAM_OFF_STAT)) begin
            clr_mask = s.prdata[`CAM_FLAGS];
        end
        if (clear_cmd) begin
            clr_mask = `CAM_FLAGS_ALL;
        end

        case (s.st)
            st_idle: begin
                next_s.st = st_idle;
            end
            st_arm: begin
                if (rif.ref_edge) begin
                    next_s.cnt = '0;
                    next_s.st = st_count;
                end
            end
            st_count: begin
                if (rif.tick) begin
                    next_s.cnt = s.cnt + CNT_ONE;
                    if (s.cnt == CNT_MAX) begin
                        events[`CAM_FLAG_OVF] = 1'b1;
                    end
                end
                if (rif.ref_edge) begin
                    fin = next_s.cnt;
                    next_s.result = fin;
                    if (in_limits(fin, s.lower, s.upper)) begin
                        events[`CAM_FLAG_MEND] = 1'b1;
                    end else begin
                        events[`CAM_FLAG_FERR] = 1'b1;
                    end
                    if (s.cont) begin
                        next_s.cnt = '0;
                        next_s.st = st_count;
                    end else begin
                        next_s.st = st_idle;
                    end
                end
            end
            default: begin
                next_s.st = st_idle;
            end
        endcase

        if (start_cmd) begin
            next_s.st = st_arm;
        end
        if (stop_cmd) begin
            next_s.st = st_idle;
        end

        // an event in the clearing cycle survives the clear
        next_s.flags = (s.flags & ~clr_mask) | events;
        next_s.irq = |(next_s.flags & next_s.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.rcfg <= ref_cfg_t'(`CAM_CFG_RST);
            s.cont <= 1'b1;
            s.mask <= `CAM_MASK_RST;
            s.upper <= `CAM_LIMIT_RST;
            s.lower <= `CAM_LIMIT_RST;
            s.flags <= `CAM_FLAGS_NONE;
            s.st <= st_idle;
            s.cnt <= '0;
            s.result <= '0;
            s.prdata <= '0;
            s.pslverr <= 1'b0;
            s.irq <= 1'b0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // a frozen block must not complete an access
    assign pready = ce;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
endmodule // clock_accuracy_monitor
`default_nettype wire

/* testbench/cam_monitor_assertions.sv */
// port-level checker for the clock accuracy monitor
// assumes a single pclk domain, bound from tb_top
`timescale 1ns/1ps
`default_nettype none
`include "cam_consts.svh"
module cam_monitor_assertions #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic [`CAM_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup_rd;
    logic acc_wr;
    assign setup_rd = psel && !penable && !pwrite && ce;
    assign acc_wr = psel && penable && pwrite && pready;
    property p_ready_ce;
        pready == ce;
    endproperty
    a_ready_ce: assert property (p_ready_ce) else $error("pready not following ce");
    property p_mapped_ok;
        setup_rd && paddr <= `CAM_OFF_RESULT && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
    property p_unmapped;
        setup_rd && paddr > `CAM_OFF_RESULT |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_cmd_zero;
        setup_rd && paddr == `CAM_OFF_CMD |=> prdata == 32'h0;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
    property p_count_width;
        setup_rd && (paddr == `CAM_OFF_COUNT || paddr == `CAM_OFF_RESULT)
            |=> prdata[31:CNT_W] == '0;
    endproperty
    a_count_width: assert property (p_count_width) else $error("count wider than counter");
    property p_irq_reset;
        $past(presetn) == 1'b0 |-> !irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset");
    property p_mask_quiet;
        acc_wr && paddr == `CAM_OFF_MASK && pwdata[2:0] == 3'h0 |-> ##[1:2] !irq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("irq despite full mask");
    // stop and clear together leave only an event of that same cycle that could raise irq again
    property p_clear_quiet;
        acc_wr && paddr == `CAM_OFF_CMD && pwdata[2:1] == 2'h3 |-> ##2 !irq [*2];
    endproperty
    a_clear_quiet: assert property (p_clear_quiet) else $error("irq after flag clear");
    c_irq: cover property ($rose(irq));
    c_err: cover property (psel && penable && pslverr);
    c_start: cover property (acc_wr && paddr == `CAM_OFF_CMD && pwdata[0]);
endmodule // cam_monitor_assertions
`default_nettype wire

/* testbench/cam_clk_src.sv */
// model of the clocks under test: measured, internal and external reference
// assumes half periods of at least 2 pclk so every level is sampled
`timescale 1ns/1ps
`default_nettype none
module cam_clk_src (
    // clock and control
    input wire logic pclk,
    input wire logic run,
    input wire logic [15:0] half [3],
    // pins: 0 measured, 1 internal reference, 2 external reference
    output logic [2:0] pins
);
    logic [15:0] cnt [3];
    // stopped pins idle low, so no edge reaches the monitor outside a run
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 3; i++) begin
            if (!run) begin
                cnt[i] <= '0;
                pins[i] <= 1'b0;
            end else if (cnt[i] + 16'h0001 >= half[i]) begin
                cnt[i] <= '0;
                pins[i] <= !pins[i];
            end else begin
                cnt[i] <= cnt[i] + 16'h0001;
            end
        end
    end
endmodule // cam_clk_src
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the clock accuracy monitor
// assumes design, clock source model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "cam_consts.svh"
module tb_top;
    localparam int CW = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic [`CAM_ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic run = 1'b0;
    logic [2:0] pins;
    logic [15:0] half [3] = '{16'h0002, 16'h0002, 16'h0100};
    logic [31:0] rst_tab [9] = '{32'h200, 0, 0, 32'h7, 0, 0, 0, 0, 0};
    int n_errors = 0;
    int cmp_count = 0;
    always #4 pclk = !pclk;
    cam_clk_src src (.pclk(pclk), .run(run), .half(half), .pins(pins));
    // small counter width makes a wrap reachable in a short run
    clock_accuracy_monitor #(.CNT_W(CW)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_clk_in(pins[0]),
        .int_ref_clk_in(pins[1]), .ext_ref_clock_in(pins[2]), .irq(irq));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("pslverr", {31'h0, err}, {31'h0, e});
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 70000) begin
            @(negedge pclk);
            n++;
        end
        chk("irq raised", 32'h1, {31'h0, irq});
    endtask
    task automatic t_reset();
        logic [31:0] v;
        for (int i = 0; i < 9; i++) begin
            rd(12'(i * 4), v);
            chk("reset value", rst_tab[i], v);
        end
        wr(12'h020, 32'h5, 1'b1);
        // a frozen block must hold off every access
        @(posedge pclk);
        ce <= 1'b0;
        @(negedge pclk);
        chk("pready while frozen", 32'h0, {31'h0, pready});
        @(posedge pclk);
        ce <= 1'b1;
    endtask
    task automatic t_cont();
        logic [31:0] v;
        wr(`CAM_OFF_UPPER, 32'h21, 1'b0);
        wr(`CAM_OFF_LOWER, 32'h1F, 1'b0);
        wr(`CAM_OFF_CMD, 32'h1, 1'b0);
        wait_irq();
        rd(`CAM_OFF_STAT, v);
        chk("busy after end", 32'h1, {31'h0, v[`CAM_STAT_BUSY]});
        wait_irq();
        wr(`CAM_OFF_CFG, 32'h0, 1'b1);
        wr(`CAM_OFF_MASK, 32'h0, 1'b0);
        repeat (2) @(negedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`CAM_OFF_CMD, 32'h6, 1'b0);
        rd(`CAM_OFF_STAT, v);
        chk("status cleared", 32'h0, v);
    endtask
    task automatic t_meas(input logic [31:0] cfg, input logic [15:0] lo, input logic [15:0] hi,
            input logic [15:0] expc, input logic ovf);
        logic [31:0] res;
        logic [31:0] v;
        logic [7:0] dif;
        logic good;
        wr(`CAM_OFF_CFG, cfg, 1'b0);
        wr(`CAM_OFF_UPPER, {16'h0, hi}, 1'b0);
        wr(`CAM_OFF_LOWER, {16'h0, lo}, 1'b0);
        wr(`CAM_OFF_MASK, ovf ? 32'h3 : 32'h7, 1'b0);
        wr(`CAM_OFF_CMD, 32'h1, 1'b0);
        wait_irq();
        rd(`CAM_OFF_RESULT, res);
        // edges are seen at tick resolution, so allow two ticks either way
        dif = res[7:0] - expc[7:0];
        chk("count", 32'h1, {31'h0, dif <= 8'h02 || dif >= 8'hFE});
        good = res[15:0] >= lo && res[15:0] <= hi;
        rd(`CAM_OFF_STAT, v);
        chk("status", {29'h0, ovf, !good, good}, v);
        rd(`CAM_OFF_COUNT, v);
        chk("count held", res, v);
        @(negedge pclk);
        chk("irq after read", 32'h0, {31'h0, irq});
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        run <= 1'b1;
        t_reset();
        t_cont();
        t_meas(32'h000, 16'h1F, 16'h21, 16'h20, 1'b0);
        t_meas(32'h001, 16'h0, 16'h1, 16'h20, 1'b0);
        t_meas(32'h002, 16'hF, 16'h11, 16'h10, 1'b0);
        t_meas(32'h080, 16'h7, 16'h8, 16'h8, 1'b0);
        t_meas(32'h1A0, 16'h3, 16'h9, 16'h4, 1'b0);
        t_meas(32'h1C0, 16'h1F, 16'h21, 16'h20, 1'b0);
        t_meas(32'h160, 16'h0, 16'h1, 16'h400, 1'b1);
        for (int f = 0; f < 4; f++) begin
            t_meas(32'h10 | 32'(f << 2), 16'h64, 16'hC8, 16'h80, 1'b0);
        end
        final_report();
    end
    initial begin
        #800000;
        n_errors++;
        $display("[FAIL] watchdog expected completion seen timeout");
        final_report();
    end
endmodule // tb_top
bind clock_accuracy_monitor cam_monitor_assertions #(.CNT_W(CNT_W)) chk_i (.pclk(pclk),
    .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
`default_nettype wire
